// >>> pkg/spi_port_pkg.sv
// Purpose: shared constants and types for the serial port core
// Assumes: APB word registers, byte address = index * 4
// Notes: pin bundles travel as packed structs
// Summary of operation
// - Phase 0: first bit out at select fall, drive on even edges, sample on odd.
// - Phase 1: drive on first edge and every second, sample on second and every second.
// - Master mode bit 1 picks order: 0 sends MSB first, 1 LSB first; resets 0.
// - Bit 0 picks transfer and interrupt mode, resets 1, steers the receive overflow flag and master start.
// - Status bit 7 reads 1 while a byte moves as master or slave, else 0.
// - Status bit 6 sets when select input enabled and asserted during a master transfer.
// - Multimaster error stays set until software writes 0 to it.
// - Polarity 0 idles the clock low with rising first edge; 1 idles high, falling.
// - Enable bit 0 switches the whole port off, 1 switches it on.
package spi_port_pkg;
  localparam int ADDR_W = 12;
  localparam int CLK_NS = 20;
  localparam int SCLK_HALF_NS = 80;
  localparam int HALF_CYC = SCLK_HALF_NS / CLK_NS;
  localparam logic [2:0] DIV_LAST = 3'(HALF_CYC - 1);
  localparam logic [4:0] EDGES = 5'h10;
  localparam logic [4:0] LAST_EDGE = 5'h0f;
  localparam logic [9:0] IDX_MODE_ONE = 10'h0e8;
  localparam logic [9:0] IDX_MODE_CTRL = 10'h0e9;
  localparam logic [9:0] IDX_STATUS = 10'h0ea;
  localparam logic [9:0] IDX_TX_DATA = 10'h0eb;
  localparam logic [9:0] IDX_RX_DATA = 10'h0ec;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h0ed;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0ee;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] MODE_WMASK = 8'h5f;
  localparam int SS_EN_BIT = 3;
  localparam int BUSY_BIT = 7;
  localparam int MULTIMASTER_ERROR_FLAG_BIT = 6;
  localparam int RXOF_BIT = 5;
  localparam int RXIRQ_BIT = 4;
  localparam int TXIRQ_BIT = 1;
  localparam int IRQ_N = 2;
  localparam int EV_DONE = 0;
  localparam int EV_MULTIMASTER_ERROR_FLAG = 1;

  typedef struct packed {
    logic rsv7;
    logic enable;
    logic rsv5;
    logic master;
    logic cpol;
    logic cpha;
    logic lsbf;
    logic transfer_irq_mode;
  } mode_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ss_n;
  } pin_in_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_n_o;
    logic ss_n_oe;
  } pin_out_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MXFER = 3'b010,
    ST_SXFER = 3'b100
  } state_t;
endpackage

// >>> rtl/pin_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes: only the second stage may be read outside
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

// >>> rtl/spi_port.sv
// Purpose: byte serial port core, master or slave, with APB registers
// Assumes: link clock far slower than pclk; pins pass pin_sync
// Notes: master clock runs at pclk / (2 * HALF_CYC)
`timescale 1ns/1ns
`default_nettype none
module spi_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spi_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire spi_port_pkg::pin_in_t pins_i,
  output spi_port_pkg::pin_out_t pins_o,
  output logic irq
);
  import spi_port_pkg::*;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-3:0] idx);
    reg_hit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic head(input logic [7:0] x, input logic lsb);
    head = lsb ? x[0] : x[7];
  endfunction

  function automatic logic [7:0] shl(input logic [7:0] x, input logic lsb);
    shl = lsb ? {1'b0, x[7:1]} : {x[6:0], 1'b0};
  endfunction

  logic [3:0] pin_s;
  logic sclk_s;
  logic mosi_s;
  logic miso_s;
  logic ssn_s;
  logic sclk_prev_q;
  logic ssn_prev_q;

  pin_sync #(.W(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({pins_i.sclk, pins_i.mosi, pins_i.miso, pins_i.ss_n}),
    .q(pin_s)
  );

  assign sclk_s = pin_s[3];
  assign mosi_s = pin_s[2];
  assign miso_s = pin_s[1];
  assign ssn_s = pin_s[0];

  mode_t mode_q;
  logic ss_en_q;
  logic [7:0] tx_data_q;
  logic [7:0] rx_data_q;
  logic [7:0] rx_data_d;
  logic tx_full_q;
  logic tx_full_d;
  logic txirq_q;
  logic txirq_d;
  logic rxirq_q;
  logic rxirq_d;
  logic rxof_q;
  logic rxof_d;
  logic multimaster_error_flag_q;
  logic multimaster_error_flag_d;
  logic [IRQ_N-1:0] irq_stat_q;
  logic [IRQ_N-1:0] irq_stat_d;
  logic [IRQ_N-1:0] irq_mask_q;
  logic [IRQ_N-1:0] ev;
  logic irq_q;

  state_t state_q;
  state_t state_d;
  logic [4:0] edge_cnt_q;
  logic [4:0] edge_cnt_d;
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic [7:0] tx_sh_q;
  logic [7:0] tx_sh_d;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_sh_d;
  logic [7:0] rx_next;
  logic [7:0] rx_fin;
  logic out_q;
  logic out_d;
  pin_out_t pins_q;
  pin_out_t pins_d;

  // APB slave: one wait state, every effect lands on the pready edge
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic acc;
  logic done;
  logic wr;
  logic rd;
  logic hit_one;
  logic hit_mode;
  logic hit_stat;
  logic hit_tx;
  logic hit_rx;
  logic hit_istat;
  logic hit_mask;
  logic mapped;
  logic [7:0] stat_rd;
  logic [7:0] rd_val;

  assign acc = psel & penable & ~pready_q;
  assign done = psel & penable & pready_q;
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;
  assign hit_one = reg_hit(paddr, IDX_MODE_ONE);
  assign hit_mode = reg_hit(paddr, IDX_MODE_CTRL);
  assign hit_stat = reg_hit(paddr, IDX_STATUS);
  assign hit_tx = reg_hit(paddr, IDX_TX_DATA);
  assign hit_rx = reg_hit(paddr, IDX_RX_DATA);
  assign hit_istat = reg_hit(paddr, IDX_IRQ_STAT);
  assign hit_mask = reg_hit(paddr, IDX_IRQ_MASK);
  assign mapped = hit_one | hit_mode | hit_stat | hit_tx | hit_rx | hit_istat | hit_mask;

  logic busy;
  logic en;
  logic is_m;
  logic lsb_mode;
  logic wr_tx;
  logic rd_rx;
  logic wr_stat;
  logic wr_istat;

  assign busy = (state_q != ST_IDLE);
  assign en = mode_q.enable;
  assign is_m = mode_q.master;
  assign lsb_mode = is_m & mode_q.lsbf;
  assign wr_tx = wr & hit_tx;
  assign rd_rx = rd & hit_rx;
  assign wr_stat = wr & hit_stat;
  assign wr_istat = wr & hit_istat;

  assign stat_rd = {busy, multimaster_error_flag_q, rxof_q, rxirq_q, 2'b00, txirq_q, 1'b0};
  assign rd_val = hit_one ? {4'h0, ss_en_q, 3'b000} :
                  hit_mode ? mode_q :
                  hit_stat ? stat_rd :
                  hit_tx ? tx_data_q :
                  hit_rx ? rx_data_q :
                  hit_istat ? {6'h00, irq_stat_q} :
                  hit_mask ? {6'h00, irq_mask_q} : 8'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc & ~mapped;
      prdata_q <= acc ? {24'h00_0000, rd_val} : prdata_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= mode_t'(MODE_RST);
      ss_en_q <= 1'b0;
      tx_data_q <= 8'h00;
      irq_mask_q <= '0;
    end
    else
    begin
      if (wr & hit_mode)
        mode_q <= mode_t'(pwdata[7:0] & MODE_WMASK);
      if (wr & hit_one)
        ss_en_q <= pwdata[SS_EN_BIT];
      if (wr_tx)
        tx_data_q <= pwdata[7:0];
      if (wr & hit_mask)
        irq_mask_q <= pwdata[IRQ_N-1:0];
    end
  end

  // Transfer engine
  logic sin;
  logic m_tick;
  logic m_edge;
  logic s_edge;
  logic edge_ev;
  logic samp;
  logic drv;
  logic m_done;
  logic s_done;
  logic byte_done;
  logic start_m;
  logic start_s;
  logic load;
  logic mm_set;
  logic head_bit;

  assign sin = is_m ? miso_s : mosi_s;
  assign m_tick = (state_q == ST_MXFER) && (div_q == DIV_LAST);
  assign m_edge = m_tick && (edge_cnt_q < EDGES);
  assign s_edge = (state_q == ST_SXFER) && (sclk_s != sclk_prev_q);
  assign edge_ev = m_edge | s_edge;
  // Even count is a first-type edge; phase picks which kind samples
  assign samp = edge_ev && (edge_cnt_q[0] == mode_q.cpha);
  assign drv = edge_ev && (edge_cnt_q[0] != mode_q.cpha);
  assign m_done = m_tick && (edge_cnt_q == EDGES);
  assign s_done = s_edge && (edge_cnt_q == LAST_EDGE);
  assign byte_done = m_done | s_done;
  // In mode 0 an unread byte stalls the next master transfer
  assign start_m = (state_q == ST_IDLE) && en && is_m && tx_full_q
                   && (mode_q.transfer_irq_mode || !rxirq_q);
  assign start_s = (state_q == ST_IDLE) && en && !is_m && ssn_prev_q && !ssn_s;
  // Slave keeps going while select stays low
  assign load = start_m | start_s | (s_done & en & ~ssn_s);
  assign mm_set = (state_q == ST_MXFER) && ss_en_q && !ssn_s;
  assign head_bit = head(tx_sh_q, lsb_mode);

  assign rx_next = lsb_mode ? {sin, rx_sh_q[7:1]} : {rx_sh_q[6:0], sin};
  assign rx_fin = samp ? rx_next : rx_sh_q;
  assign rx_sh_d = samp ? rx_next : rx_sh_q;
  assign rx_data_d = byte_done ? rx_fin : rx_data_q;

  // Phase 0 presents the first bit at load; phase 1 waits for edge 0
  assign out_d = load ? (mode_q.cpha ? out_q : head(tx_data_q, lsb_mode)) :
                 drv ? head_bit : out_q;
  assign tx_sh_d = load ? (mode_q.cpha ? tx_data_q : shl(tx_data_q, lsb_mode)) :
                   drv ? shl(tx_sh_q, lsb_mode) : tx_sh_q;

  assign edge_cnt_d = load ? 5'h00 : edge_ev ? edge_cnt_q + 5'h01 : edge_cnt_q;
  assign div_d = ((state_q == ST_MXFER) && !m_tick) ? div_q + 3'h1 : 3'h0;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (start_m)
          state_d = ST_MXFER;
        else if (start_s)
          state_d = ST_SXFER;
      end
      ST_MXFER:
      begin
        // A competing master aborts the byte in flight
        if (!en || mm_set || m_done)
          state_d = ST_IDLE;
      end
      ST_SXFER:
      begin
        if (!en || ssn_s || (s_done && !load))
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      edge_cnt_q <= 5'h00;
      div_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      edge_cnt_q <= edge_cnt_d;
      div_q <= div_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      rx_data_q <= 8'h00;
      out_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      ssn_prev_q <= 1'b1;
    end
    else
    begin
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      rx_data_q <= rx_data_d;
      out_q <= out_d;
      sclk_prev_q <= sclk_s;
      ssn_prev_q <= ssn_s;
    end
  end

  // Status flags: a hardware set always beats a software clear
  assign tx_full_d = wr_tx | (tx_full_q & ~load);
  assign txirq_d = (load & tx_full_q) | (txirq_q & ~wr_tx);
  assign rxirq_d = byte_done | (rxirq_q & ~rd_rx);
  assign rxof_d = (byte_done & rxirq_q & mode_q.transfer_irq_mode) | (rxof_q & ~rd_rx);
  assign multimaster_error_flag_d = mm_set | (multimaster_error_flag_q & ~(wr_stat & ~pwdata[MULTIMASTER_ERROR_FLAG_BIT]));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_full_q <= 1'b0;
      txirq_q <= 1'b0;
      rxirq_q <= 1'b0;
      rxof_q <= 1'b0;
      multimaster_error_flag_q <= 1'b0;
    end
    else
    begin
      tx_full_q <= tx_full_d;
      txirq_q <= txirq_d;
      rxirq_q <= rxirq_d;
      rxof_q <= rxof_d;
      multimaster_error_flag_q <= multimaster_error_flag_d;
    end
  end

  assign ev[EV_DONE] = byte_done;
  assign ev[EV_MULTIMASTER_ERROR_FLAG] = mm_set;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi++)
    begin : g_irq
      assign irq_stat_d[gi] = ev[gi] | (irq_stat_q[gi] & ~(wr_istat & pwdata[gi]));
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  // Pins; the clock parks at the polarity level between bytes
  assign pins_d = '{
    sclk_o: (state_q == ST_MXFER) ? (pins_q.sclk_o ^ m_edge) : mode_q.cpol,
    sclk_oe: en & is_m,
    mosi_o: out_d,
    mosi_oe: en & is_m,
    miso_o: out_d,
    miso_oe: (state_d == ST_SXFER),
    ss_n_o: (state_d != ST_MXFER),
    ss_n_oe: en & is_m & ~ss_en_q
  };

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pins_q <= '{sclk_o: 1'b0, sclk_oe: 1'b0, mosi_o: 1'b0, mosi_oe: 1'b0,
                  miso_o: 1'b0, miso_oe: 1'b0, ss_n_o: 1'b1, ss_n_oe: 1'b0};
    else
      pins_q <= pins_d;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pins_o = pins_q;
  assign irq = irq_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_master_start;
    start_m && !ss_en_q;
  endsequence

  sequence s_cpha0_load;
    start_m && !mode_q.cpha;
  endsequence

  property p_frame_len;
    s_master_start |-> ##68 (byte_done || !mode_q.enable);
  endproperty

  property p_cpha0_first;
    s_cpha0_load |=> pins_q.mosi_o == (mode_q.lsbf ? $past(tx_data_q[0]) : $past(tx_data_q[7]));
  endproperty

  chk_busy_flag: assert property ((!pins_q.ss_n_o || pins_q.miso_oe) |-> stat_rd[BUSY_BIT])
    else $error("busy flag low during transfer");
  chk_multimaster_error_flag_set: assert property (mm_set |=> multimaster_error_flag_q && state_q == ST_IDLE)
    else $error("multimaster error not raised");
  chk_multimaster_error_flag_hold: assert property (multimaster_error_flag_q && !(wr_stat && !pwdata[MULTIMASTER_ERROR_FLAG_BIT]) |=> multimaster_error_flag_q)
    else $error("multimaster error lost");
  chk_sclk_idle: assert property ((state_q == ST_IDLE) [*2] |-> pins_q.sclk_o == $past(mode_q.cpol))
    else $error("clock not parked at polarity");
  chk_port_off: assert property (!mode_q.enable |=> state_q == ST_IDLE && !pins_q.mosi_oe)
    else $error("port active while disabled");
  chk_frame_len: assert property (p_frame_len)
    else $error("master byte not 68 cycles");
  chk_cpha0_first: assert property (p_cpha0_first)
    else $error("first bit wrong at select fall");
  chk_cpha1_drive: assert property (m_edge && mode_q.cpha && edge_cnt_q == 5'h00
                                    |=> pins_q.mosi_o == $past(head_bit))
    else $error("phase 1 first edge did not drive");
  chk_transfer_irq_mode_stall: assert property (!mode_q.transfer_irq_mode && rxirq_q && state_q == ST_IDLE
                                     |=> state_q != ST_MXFER)
    else $error("mode 0 started with unread byte");
  chk_slave_edge: assert property (s_edge && edge_cnt_q < LAST_EDGE
                                   |=> edge_cnt_q == $past(edge_cnt_q) + 5'h01)
    else $error("slave edge not counted");
endmodule // spi_port
`default_nettype wire

// >>> verif/spi_far_model.sv
// Purpose: behavioural far-side slave for the port in master mode
// Assumes: phase and polarity set by the bench to match the port
// Notes: a released data line toggles so stale levels never pass
`timescale 1ns/1ns
`default_nettype none
module spi_far_model (
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte,
  output logic pol_err
);
  int edge_n;
  logic [7:0] sh;
  initial
  begin
    miso = 1'b1;
    rx_byte = 8'h00;
    pol_err = 1'b0;
    edge_n = 0;
  end
  always @(negedge ss_n)
  begin
    edge_n = 0;
    sh = tx_byte;
    if (!cpha)
      miso = sh[7];
  end
  // Not selected: never leave the last bit standing
  always @(posedge ss_n)
    miso = ~miso;
  always @(sclk)
  begin
    if (!ss_n)
    begin
      edge_n = edge_n + 1;
      if (edge_n == 1 && sclk === cpol)
        pol_err = 1'b1;
      if ((edge_n % 2 == 1) == (cpha == 1'b0))
        rx_byte = {rx_byte[6:0], mosi};
      else if (edge_n < 16)
        miso = sh[7 - edge_n / 2];
    end
  end
endmodule // spi_far_model
`default_nettype wire

// >>> verif/spi_port_tb.sv
// Purpose: self-checking bench for the serial port core
// Assumes: APB master tasks, far slave model, bench-driven master frames
// Notes: select line is wired-and with a pull-up
`timescale 1ns/1ns
`default_nettype none
module spi_port_tb;
  import spi_port_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, v;
  wire pin_in_t pins_i;
  pin_out_t pins_o;
  logic tb_sclk, tb_mosi, tb_ss_n, far_miso, far_cpol, far_cpha, pol_err;
  logic [7:0] far_tx, far_rx, txb, got;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  assign pins_i.sclk = pins_o.sclk_oe ? pins_o.sclk_o : tb_sclk;
  assign pins_i.mosi = pins_o.mosi_oe ? pins_o.mosi_o : tb_mosi;
  assign pins_i.miso = pins_o.miso_oe ? pins_o.miso_o : far_miso;
  assign pins_i.ss_n = (pins_o.ss_n_oe ? pins_o.ss_n_o : 1'b1) & tb_ss_n;
  spi_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_i(pins_i), .pins_o(pins_o), .irq(irq));
  spi_far_model far (.sclk(pins_i.sclk), .ss_n(pins_i.ss_n), .mosi(pins_i.mosi), .cpol(far_cpol),
    .cpha(far_cpha), .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx), .pol_err(pol_err));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] x);
    for (int i = 0; i < 8; i++)
      rev8[i] = x[7 - i];
  endfunction
  // Waits as long as the slave needs; only the cycle ceiling ends a hang
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    v = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 300)
    begin
      n++;
      @(posedge pclk);
    end
  endtask
  // Bench acts as master; samples the port before its own drive edge
  task automatic slave_frame(input logic cpha, input logic [7:0] mo, output logic [7:0] mi);
    tb_ss_n <= 1'b0;
    tb_mosi <= mo[7];
    repeat (8) @(posedge pclk);
    for (int e = 1; e <= 16; e++)
    begin
      tb_sclk <= ~tb_sclk;
      if ((e % 2 == 1) == (cpha == 1'b0))
        mi = {mi[6:0], pins_i.miso};
      else if (e < 16)
        tb_mosi <= mo[7 - e / 2];
      repeat (4) @(posedge pclk);
    end
    tb_ss_n <= 1'b1;
    tb_mosi <= ~tb_mosi;
    repeat (8) @(posedge pclk);
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, tb_sclk, tb_mosi, far_cpol, far_cpha} = 8'h00;
    paddr = '0;
    pwdata = 32'h00000000;
    tb_ss_n = 1'b1;
    far_tx = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, IDX_MODE_CTRL, 8'h00); check(v, 32'h00000001);
    apb(1'b0, IDX_STATUS, 8'h00); check(v, 32'h00000000);
    apb(1'b0, 10'h000, 8'h00); check(v, 32'h00000000);
    check(last_err, 1'b1);
    check(pins_o.sclk_oe, 1'b0);
    $display("test reset values done");
    apb(1'b1, IDX_IRQ_MASK, 8'h01);
    for (int m = 0; m < 8; m++)
    begin
      txb = 8'h1d + 8'(m);
      far_cpol <= m[2];
      far_cpha <= m[1];
      far_tx <= ~txb;
      apb(1'b1, IDX_MODE_CTRL, {4'h5, m[2], m[1], m[0], 1'b1});
      // Parked level reaches the pin one edge after the write lands
      @(posedge pclk);
      check(pins_o.sclk_o, m[2]);
      apb(1'b1, IDX_TX_DATA, txb);
      apb(1'b0, IDX_STATUS, 8'h00); check(v[7], 1'b1);
      wait_irq(1'b1); check(irq, 1'b1);
      check(far_rx, m[0] ? rev8(txb) : txb);
      check(pins_o.ss_n_o, 1'b1);
      apb(1'b0, IDX_RX_DATA, 8'h00);
      check(v, {24'h000000, m[0] ? rev8(~txb) : ~txb});
      apb(1'b0, IDX_STATUS, 8'h00); check(v[7], 1'b0);
      apb(1'b1, IDX_IRQ_STAT, 8'h01);
      wait_irq(1'b0); check(irq, 1'b0);
      check(pol_err, 1'b0);
    end
    $display("test master modes done");
    // Mode 0: an unread byte must hold back the next master byte
    {far_cpol, far_cpha} <= 2'b00;
    far_tx <= 8'hc3;
    apb(1'b1, IDX_MODE_CTRL, 8'h50);
    apb(1'b1, IDX_TX_DATA, 8'h3c);
    wait_irq(1'b1); check(far_rx, 8'h3c);
    apb(1'b1, IDX_IRQ_STAT, 8'h01);
    apb(1'b1, IDX_TX_DATA, 8'hc3);
    repeat (80) @(posedge pclk);
    apb(1'b0, IDX_STATUS, 8'h00); check(v, 32'h00000010);
    apb(1'b0, IDX_RX_DATA, 8'h00); check(v, 32'h000000c3);
    wait_irq(1'b1); check(far_rx, 8'hc3);
    apb(1'b0, IDX_RX_DATA, 8'h00); check(v, 32'h000000c3);
    apb(1'b1, IDX_IRQ_STAT, 8'h01);
    wait_irq(1'b0); check(irq, 1'b0);
    $display("test transfer mode zero done");
    apb(1'b1, IDX_IRQ_MASK, 8'h00);
    apb(1'b1, IDX_MODE_ONE, 8'h08);
    apb(1'b1, IDX_TX_DATA, 8'h66);
    repeat (10) @(posedge pclk);
    tb_ss_n <= 1'b0;
    repeat (6) @(posedge pclk);
    tb_ss_n <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, IDX_STATUS, 8'h00); check(v[7:6], 2'b01);
    check(irq, 1'b0);
    apb(1'b1, IDX_STATUS, 8'h40);
    apb(1'b0, IDX_STATUS, 8'h00); check(v[6], 1'b1);
    apb(1'b1, IDX_IRQ_MASK, 8'h02);
    wait_irq(1'b1); check(irq, 1'b1);
    apb(1'b1, IDX_STATUS, 8'h00);
    apb(1'b0, IDX_STATUS, 8'h00); check(v[6], 1'b0);
    apb(1'b1, IDX_IRQ_STAT, 8'h02);
    wait_irq(1'b0); check(irq, 1'b0);
    apb(1'b1, IDX_MODE_ONE, 8'h00);
    $display("test multimaster error done");
    tb_sclk <= 1'b1;
    apb(1'b1, IDX_MODE_CTRL, 8'h4d);
    apb(1'b1, IDX_TX_DATA, 8'hb4);
    fork
      slave_frame(1'b1, 8'h2e, got);
      begin
        repeat (30) @(posedge pclk);
        apb(1'b0, IDX_STATUS, 8'h00); check(v[7], 1'b1);
      end
    join
    check(got, 8'hb4);
    apb(1'b0, IDX_RX_DATA, 8'h00); check(v, 32'h0000002e);
    apb(1'b0, IDX_STATUS, 8'h00); check(v[7], 1'b0);
    $display("test slave mode done");
    apb(1'b1, IDX_MODE_CTRL, 8'h11);
    apb(1'b1, IDX_TX_DATA, 8'h55);
    repeat (10) @(posedge pclk);
    apb(1'b0, IDX_STATUS, 8'h00); check(v[7], 1'b0);
    check({pins_o.sclk_oe, pins_o.mosi_oe}, 2'b00);
    $display("test port disable done");
    print_verdict();
  end
endmodule // spi_port_tb
`default_nettype wire
